// ==== logic/adcdpc_pkg.sv ====
package adcdpc_pkg;
    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_DEV_CTRL = 8'h25;
    localparam logic [7:0] IDX_PKT_FMT = 8'h26;
    localparam logic [7:0] IDX_FLAGS = 8'h30;
    localparam logic [7:0] IDX_MASK = 8'h31;
    localparam logic [7:0] IDX_PATTERN = 8'h32;
    localparam logic [7:0] IDX_STATUS = 8'h33;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] A_DEV_CTRL = {IDX_DEV_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_PKT_FMT = {IDX_PKT_FMT, 2'b00};
    localparam logic [ADDR_W-1:0] A_FLAGS = {IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] A_PATTERN = {IDX_PATTERN, 2'b00};
    localparam logic [ADDR_W-1:0] A_STATUS = {IDX_STATUS, 2'b00};
    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int DC_INJECT = 7;
    localparam int DC_TERM = 4;
    localparam int DC_HALF_BIAS = 3;
    localparam int DC_BUF_PD = 2;
    localparam int DC_REF_SEL = 1;
    localparam int DC_ECHO = 0;
    localparam logic [7:0] DC_WMASK = 8'h9F;
    localparam logic [7:0] DC_RESET = 8'h11;
    localparam int PF_PATTERN = 2;
    localparam logic [7:0] PF_WMASK = 8'h07;
    localparam logic [7:0] PF_RESET = 8'h01;
    localparam logic [1:0] SIZE_16 = 2'h0;
    localparam logic [1:0] SIZE_24 = 2'h1;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_24 = 5'h18;
    // Flag bits
    localparam int FL_FUSE = 0;
    localparam int FL_CFG = 1;
    localparam int FL_PKT = 2;
    localparam int FLAG_W = 3;
    localparam int PKT_MAX = 24;
endpackage

// ==== logic/adcdpc_sync.sv ====
`timescale 1ns/10ps
module adcdpc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ==== logic/adcdpc_shifter.sv ====
`timescale 1ns/10ps
// Shifts one packet out MSB first on falling link clock edges
module adcdpc_shifter #(
    parameter int PKT_MAX = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [PKT_MAX-1:0] word,
    input wire logic [4:0] nbits,
    input wire logic shift,
    output logic dout,
    output logic busy
);
    logic [PKT_MAX-1:0] sr_q;
    logic [4:0] cnt_q;

    // Five-bit count and the 24-bit word bound the range
    if (PKT_MAX < 24 || PKT_MAX > 31) begin : g_bad_pkt_max
        $error("PKT_MAX out of range");
    end

    assign busy = (cnt_q != 5'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= '0;
            cnt_q <= 5'h00;
            dout <= 1'b0;
        end else if (load) begin
            sr_q <= word;
            cnt_q <= nbits;
        end else if (shift && busy) begin
            dout <= sr_q[PKT_MAX-1];
            sr_q <= {sr_q[PKT_MAX-2:0], 1'b0};
            cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule

// ==== logic/adcdpc_top.sv ====
`timescale 1ns/10ps
module adcdpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock_in,
    input wire logic convert_start,
    input wire logic oversample_active,
    input wire logic [23:0] conv_data,
    input wire logic fuse_crc_error,
    input wire logic config_crc_error,
    output logic echoed_clock_out,
    output logic data_out,
    output logic lvds_term_enable,
    output logic lvds_half_bias,
    output logic ref_buffer_powerdown,
    output logic internal_ref_powerdown,
    output logic crc_selftest_inject,
    output logic irq
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] dev_ctrl_q;
    logic [7:0] pkt_fmt_q;
    logic [15:0] channel_pattern_value_q;
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] mask_q;
    logic [31:0] rdata_d;
    logic echo_q;
    logic sck_prev_q;
    logic sck_s;
    logic conv_s;
    logic conv_prev_q;
    logic running_q;
    logic [23:0] word_d;
    logic [4:0] nbits_d;
    logic load;
    logic busy;
    logic fuse_err_s;
    logic cfg_err_s;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Packet length in bits for a stored size code
    function automatic logic [4:0] pkt_len(input logic [1:0] code);
        if (code == adcdpc_pkg::SIZE_24) begin
            return adcdpc_pkg::LEN_24;
        end
        return adcdpc_pkg::LEN_16;
    endfunction

    // Only the two defined size codes may be stored
    function automatic logic size_legal(input logic [1:0] code);
        return (code == adcdpc_pkg::SIZE_16) || (code == adcdpc_pkg::SIZE_24);
    endfunction

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    adcdpc_sync u_sync_sck (
        .pclk(pclk),
        .presetn(presetn),
        .d(serial_clock_in),
        .q(sck_s)
    );
    adcdpc_sync u_sync_cnv (
        .pclk(pclk),
        .presetn(presetn),
        .d(convert_start),
        .q(conv_s)
    );
    adcdpc_sync u_sync_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .d(fuse_crc_error),
        .q(fuse_err_s)
    );
    adcdpc_sync u_sync_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .d(config_crc_error),
        .q(cfg_err_s)
    );

    // ----------------------------------------------------------------
    // APB decode, zero wait states
    // ----------------------------------------------------------------
    wire wr_en = psel && penable && pwrite;
    wire hit_dc = (paddr == adcdpc_pkg::A_DEV_CTRL);
    wire hit_pf = (paddr == adcdpc_pkg::A_PKT_FMT);
    wire hit_fl = (paddr == adcdpc_pkg::A_FLAGS);
    wire hit_mk = (paddr == adcdpc_pkg::A_MASK);
    wire hit_pt = (paddr == adcdpc_pkg::A_PATTERN);
    wire hit_st = (paddr == adcdpc_pkg::A_STATUS);
    wire hit_any = hit_dc | hit_pf | hit_fl | hit_mk | hit_pt | hit_st;
    wire [1:0] size_wr = pwdata[1:0];
    wire size_ok = size_legal(size_wr);

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!hit_any || (pwrite && hit_pf && !size_ok));

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_dc) begin
            rdata_d[7:0] = dev_ctrl_q;
        end
        if (hit_pf) begin
            rdata_d[7:0] = pkt_fmt_q;
        end
        if (hit_fl) begin
            rdata_d[2:0] = flags_q;
        end
        if (hit_mk) begin
            rdata_d[2:0] = mask_q;
        end
        if (hit_pt) begin
            rdata_d[15:0] = channel_pattern_value_q;
        end
        if (hit_st) begin
            rdata_d[1:0] = {running_q, busy};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_ctrl_q <= adcdpc_pkg::DC_RESET;
            pkt_fmt_q <= adcdpc_pkg::PF_RESET;
            mask_q <= 3'h0;
            channel_pattern_value_q <= 16'h0000;
        end else if (wr_en) begin
            if (hit_dc) begin
                dev_ctrl_q <= pwdata[7:0] & adcdpc_pkg::DC_WMASK;
            end
            if (hit_pf && size_ok) begin
                pkt_fmt_q <= pwdata[7:0] & adcdpc_pkg::PF_WMASK;
            end
            if (hit_mk) begin
                mask_q <= pwdata[2:0];
            end
            if (hit_pt) begin
                channel_pattern_value_q <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    assign lvds_term_enable = dev_ctrl_q[adcdpc_pkg::DC_TERM];
    assign lvds_half_bias = dev_ctrl_q[adcdpc_pkg::DC_HALF_BIAS];
    assign ref_buffer_powerdown = dev_ctrl_q[adcdpc_pkg::DC_BUF_PD];
    assign internal_ref_powerdown = dev_ctrl_q[adcdpc_pkg::DC_REF_SEL];
    wire inject = dev_ctrl_q[adcdpc_pkg::DC_INJECT] && running_q;
    assign crc_selftest_inject = inject;

    // Clock echo follows the sampled link clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_q <= 1'b0;
        end else begin
            echo_q <= sck_s && dev_ctrl_q[adcdpc_pkg::DC_ECHO];
        end
    end
    assign echoed_clock_out = echo_q;

    // ----------------------------------------------------------------
    // Conversion framing and flags
    // ----------------------------------------------------------------
    wire sck_fall = sck_prev_q && !sck_s;
    wire conv_rise = conv_s && !conv_prev_q;
    assign load = conv_rise && !busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b0;
            conv_prev_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            conv_prev_q <= conv_s;
            running_q <= conv_s;
        end
    end

    wire [2:0] flag_set = {conv_rise && busy,
                           cfg_err_s || inject,
                           fuse_err_s || inject};
    wire [2:0] flag_clr = (wr_en && hit_fl) ? pwdata[2:0] : 3'h0;
    assign flags_d = (flags_q & ~flag_clr) | flag_set;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign irq = |(flags_q & mask_q);

    // ----------------------------------------------------------------
    // Packet formatting
    // ----------------------------------------------------------------
    wire pattern_on = pkt_fmt_q[adcdpc_pkg::PF_PATTERN];
    always_comb begin
        word_d = 24'h00_0000;
        if (pattern_on) begin
            word_d = {channel_pattern_value_q, 8'h00};
        end else if (oversample_active) begin
            word_d = conv_data;
        end else begin
            word_d = {conv_data[23:8], 8'h00};
        end
        nbits_d = pkt_len(pkt_fmt_q[1:0]);
    end

    adcdpc_shifter #(
        .PKT_MAX(adcdpc_pkg::PKT_MAX)
    ) u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .load(load),
        .word(word_d),
        .nbits(nbits_d),
        .shift(sck_fall),
        .dout(data_out),
        .busy(busy)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_INJECT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        inject |=> flags_q[adcdpc_pkg::FL_FUSE] && flags_q[adcdpc_pkg::FL_CFG])
        else $error("inject did not set flags");

    AST_INJECT_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        dev_ctrl_q[adcdpc_pkg::DC_INJECT] && conv_s && !(wr_en && hit_dc) |=> crc_selftest_inject)
        else $error("inject missing while running");

    AST_CFG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_err_s |=> flags_q[adcdpc_pkg::FL_CFG])
        else $error("config flag not set");

    AST_TERM: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_dc |=> lvds_term_enable == $past(pwdata[adcdpc_pkg::DC_TERM]))
        else $error("term mismatch");

    AST_HALF_BIAS: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_dc |=> lvds_half_bias == $past(pwdata[adcdpc_pkg::DC_HALF_BIAS]))
        else $error("half bias mismatch");

    AST_BUF_PD: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_dc |=> ref_buffer_powerdown == $past(pwdata[adcdpc_pkg::DC_BUF_PD]))
        else $error("buffer power down mismatch");

    AST_REF_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_dc |=> internal_ref_powerdown == $past(pwdata[adcdpc_pkg::DC_REF_SEL]))
        else $error("reference select mismatch");

    AST_ECHO_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !dev_ctrl_q[adcdpc_pkg::DC_ECHO] |=> !echoed_clock_out)
        else $error("echo while off");

    AST_ECHO_ON: assert property (@(posedge pclk) disable iff (!presetn)
        dev_ctrl_q[adcdpc_pkg::DC_ECHO] && sck_s |=> echoed_clock_out)
        else $error("echo missing");

    AST_PATTERN: assert property (@(posedge pclk) disable iff (!presetn)
        load && pattern_on |-> word_d[23:8] == channel_pattern_value_q)
        else $error("pattern");

    AST_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> busy && u_shift.cnt_q == pkt_len($past(pkt_fmt_q[1:0])))
        else $error("length");

    AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
        conv_rise && busy |=> flags_q[adcdpc_pkg::FL_PKT])
        else $error("overrun not flagged");

    AST_SIZE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
        size_legal(pkt_fmt_q[1:0]))
        else $error("reserved size stored");

    AST_PF_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_pf && !size_legal(pwdata[1:0]) |=> $stable(pkt_fmt_q))
        else $error("reserved size write took effect");

    AST_OVS_WORD: assert property (@(posedge pclk) disable iff (!presetn)
        load && !pattern_on && oversample_active |-> word_d == conv_data)
        else $error("oversampled word");

    AST_SHIFT_MSB: assert property (@(posedge pclk) disable iff (!presetn)
        sck_fall && busy |=> data_out == $past(u_shift.sr_q[adcdpc_pkg::PKT_MAX-1]))
        else $error("bit order");

    AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        flags_q[adcdpc_pkg::FL_FUSE] && !(wr_en && hit_fl && pwdata[adcdpc_pkg::FL_FUSE])
        |=> flags_q[adcdpc_pkg::FL_FUSE]) else $error("flag lost");

    AST_FUSE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        fuse_err_s |=> flags_q[adcdpc_pkg::FL_FUSE])
        else $error("fuse flag not set");

    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_fl && pwdata[adcdpc_pkg::FL_FUSE] && !fuse_err_s && !inject |=> !flags_q[adcdpc_pkg::FL_FUSE])
        else $error("fuse flag not cleared");

    AST_RSVD_DC: assert property (@(posedge pclk) disable iff (!presetn)
        dev_ctrl_q[6:5] == 2'b00 && pkt_fmt_q[7:3] == 5'h00)
        else $error("reserved bits set");

    AST_RD_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && (hit_dc || hit_pf) |-> prdata[31:8] == 24'h00_0000)
        else $error("reserved read bits set");
endmodule

// ==== tb/adcdpc_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side: link clock source and packet reader
// ----------------------------------------------------------------
module adcdpc_host_model (
    input wire logic pclk,
    input wire logic data_out,
    output logic serial_clock_in,
    output logic convert_start
);
    initial begin
        serial_clock_in = 1'b1;
        convert_start = 1'b0;
    end
    task automatic set_link(input logic sck, input logic conv);
        @(posedge pclk);
        serial_clock_in <= sck;
        convert_start <= conv;
    endtask
    // Link clock idles high and capture toggles it only inside a frame, 4 pclk per phase
    // Each bit is taken just before the next fall, well after the data has moved
    task automatic capture(input int n, output logic [23:0] w);
        w = 24'h0;
        set_link(1'b1, 1'b1);
        repeat (6) @(posedge pclk);
        for (int i = 0; i <= n; i++) begin
            if (i > 0) w = {w[22:0], data_out};
            if (i < n) set_link(1'b0, 1'b1);
            repeat (3) @(posedge pclk);
            set_link(1'b1, 1'b1);
            repeat (3) @(posedge pclk);
        end
        set_link(1'b1, 1'b0);
    endtask
endmodule

// ==== tb/adc_device_and_packet_control_tb_top.sv ====
`timescale 1ns/10ps
module adc_device_and_packet_control_tb_top;
    typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] r; logic [3:0] o;} adcdpc_row_t;
    typedef struct packed {logic [7:0] pf; logic ovs; logic [23:0] d; logic [4:0] n; logic [23:0] x;} adcdpc_pkt_t;
    localparam logic [9:0] DC = adcdpc_pkg::A_DEV_CTRL;
    localparam logic [9:0] PF = adcdpc_pkg::A_PKT_FMT;
    localparam logic [9:0] FL = adcdpc_pkg::A_FLAGS;
    localparam logic [9:0] MK = adcdpc_pkg::A_MASK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sck, conv, ovs, fuse_err, cfg_err;
    logic echo, dout, term, half, bufpd, refpd, inject, irq, e;
    logic inj_seen = 1'b0;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] conv_data, w;
    int miscompares = 0;
    int n_tests = 0;
    adcdpc_row_t rows [7] = '{'{DC, 8'hFF, 8'h9F, 4'hF}, '{DC, 8'h00, 8'h00, 4'h0}, '{DC, 8'h0A, 8'h0A, 4'h5},
        '{DC, 8'h11, 8'h11, 4'h8}, '{PF, 8'hF8, 8'h00, 4'h8}, '{PF, 8'h05, 8'h05, 4'h8}, '{PF, 8'h01, 8'h01, 4'h8}};
    adcdpc_pkt_t pk [3] = '{'{8'h01, 1'b1, 24'hABCDEF, 5'h18, 24'hABCDEF},
        '{8'h00, 1'b0, 24'h12345F, 5'h10, 24'h001234}, '{8'h04, 1'b0, 24'h777777, 5'h10, 24'h00A5C3}};
    adcdpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_in(sck), .convert_start(conv), .oversample_active(ovs), .conv_data(conv_data),
        .fuse_crc_error(fuse_err), .config_crc_error(cfg_err), .echoed_clock_out(echo), .data_out(dout),
        .lvds_term_enable(term), .lvds_half_bias(half), .ref_buffer_powerdown(bufpd),
        .internal_ref_powerdown(refpd), .crc_selftest_inject(inject), .irq(irq));
    adcdpc_host_model host (.pclk(pclk), .data_out(dout), .serial_clock_in(sck), .convert_start(conv));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Both check engines report an error while the device injects one
    always @(posedge pclk) begin
        fuse_err <= inject;
        cfg_err <= inject;
        if (inject === 1'b1) inj_seen <= 1'b1;
    end
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [9:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, ovs} = '0;
        paddr = '0;
        pwdata = '0;
        conv_data = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, DC, 0);
        chk(r, 32'h11);
        apb(0, PF, 0);
        chk(r, 32'h01);
        chk({term, half, bufpd, refpd, inject}, 5'h10);
        $display("reset done");
        foreach (rows[k]) begin
            apb(1, rows[k].a, {8'h00, rows[k].w});
            chk(e, 0);
            apb(0, rows[k].a, 0);
            chk(r, rows[k].r);
            chk({term, half, bufpd, refpd}, rows[k].o);
        end
        $display("rows done");
        for (int c = 2; c < 4; c++) begin
            apb(1, PF, c[15:0]);
            chk(e, 1);
        end
        apb(0, PF, 0);
        chk(r, 32'h01);
        apb(0, 10'h3FC, 0);
        chk(e, 1);
        $display("refusal done");
        host.set_link(1'b0, 1'b0);
        repeat (6) @(posedge pclk);
        chk(echo, 0);
        host.set_link(1'b1, 1'b0);
        repeat (6) @(posedge pclk);
        chk(echo, 1);
        apb(1, DC, 16'h0090);
        repeat (4) @(posedge pclk);
        chk(echo, 0);
        $display("echo done");
        apb(1, MK, 16'h0003);
        host.capture(24, w);
        repeat (4) @(posedge pclk);
        chk(inject, 0);
        chk(inj_seen, 1);
        apb(0, FL, 0);
        chk(r, 32'h3);
        chk(irq, 1);
        apb(1, FL, 16'h0001);
        apb(0, FL, 0);
        chk(r, 32'h2);
        apb(1, FL, 16'h0002);
        @(posedge pclk);
        chk(irq, 0);
        apb(1, DC, 16'h0011);
        $display("self test done");
        apb(1, adcdpc_pkg::A_PATTERN, 16'hA5C3);
        foreach (pk[k]) begin
            apb(1, PF, {8'h00, pk[k].pf});
            ovs <= pk[k].ovs;
            conv_data <= pk[k].d;
            host.capture(int'(pk[k].n), w);
            chk(w, pk[k].x);
        end
        $display("packets done");
        apb(0, adcdpc_pkg::A_PATTERN, 0);
        chk(r, 32'hA5C3);
        host.set_link(1'b1, 1'b1);
        repeat (6) @(posedge pclk);
        host.set_link(1'b1, 1'b0);
        repeat (6) @(posedge pclk);
        host.set_link(1'b1, 1'b1);
        repeat (6) @(posedge pclk);
        apb(0, FL, 0);
        chk(r, 32'h4);
        apb(0, adcdpc_pkg::A_STATUS, 0);
        chk(r, 32'h3);
        $display("overrun done");
        apb(1, DC, 16'h000A);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, DC, 0);
        chk(r, 32'h11);
        apb(0, PF, 0);
        chk(r, 32'h01);
        apb(0, FL, 0);
        chk(r, 32'h0);
        $display("reset again done");
        end_sim();
    end
endmodule
